/* src/flash_bank_remap_pkg.sv */
// Purpose: Shared constants and types for the code-flash bank and remap control.
// Assumes: 8 MB code flash, byte addressed, halves split by the top address bit.
// Notes: Mapping swaps the two halves; bank mode decides read-while-write isolation.
package flash_bank_remap_pkg;

  localparam int ADDR_W = 23;
  localparam int BANK_BIT = ADDR_W - 1;
  localparam int ENTRY_W = 32;

  //////////////////////////////////////////////////////////////////////////////
  // Encodings and values after reset
  localparam logic BANK_MODE_SINGLE = 1'b0;
  localparam logic BANK_MODE_DUAL = 1'b1;
  localparam logic MAP_A = 1'b0;
  localparam logic MAP_B = 1'b1;
  localparam logic BANK_MODE_RST = BANK_MODE_SINGLE;
  localparam logic MAP_RST = MAP_A;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PHYS_ADDR_RST = 23'h00_0000;

  //////////////////////////////////////////////////////////////////////////////
  // Protection states seen by flash boot
  localparam logic [1:0] PROT_VIRGIN = 2'h0;
  localparam logic [1:0] PROT_NORMAL = 2'h1;
  localparam logic [1:0] PROT_SECURE = 2'h2;
  localparam logic [1:0] PROT_DEAD = 2'h3;

  typedef enum {BOOT_ROM_CHECK, BOOT_DEBUG_CFG, BOOT_APP_CHECK, BOOT_APP_RUN, BOOT_IDLE} boot_state_t;
  typedef enum {LC_OPEN, LC_HASH, LC_FUSE, LC_SECURE} life_state_t;

  // Physical half reached by an address under the given mapping
  function automatic logic phys_half(input logic map, input logic addr_msb);
    phys_half = addr_msb ^ map;
  endfunction : phys_half

endpackage : flash_bank_remap_pkg

/* src/flash_bank_remap_control.sv */
// Purpose: Bank mode and remap bits, boot hand-off, lifecycle lock, fetch mapping.
// Assumes: All inputs come from logic on mclk; check agents answer with done pulses.
// Notes: Configuration is not retained across reset; software keeps its own marker.
`timescale 1ns/1ps
`default_nettype none

module flash_bank_remap_control
  import flash_bank_remap_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ctl_write,
  input wire logic ctl_bank_mode_in,
  input wire logic ctl_map_in,
  output logic bank_mode,
  output logic map_select,
  output logic supervisory_flash_check_req,
  input wire logic supervisory_flash_check_done,
  input wire logic supervisory_flash_check_ok,
  input wire logic [1:0] protection_state,
  output logic debug_port_enable,
  output logic app_check_req,
  input wire logic app_check_done,
  input wire logic app_check_ok,
  input wire logic [ENTRY_W-1:0] app_entry_addr,
  output logic [ENTRY_W-1:0] boot_entry,
  output logic app_running,
  output logic boot_idle,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_ready,
  output logic fetch_valid,
  output logic [ADDR_W-1:0] fetch_phys_addr,
  input wire logic prog_active,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic lc_secure_req,
  output logic hash_req,
  input wire logic hash_done,
  output logic fuse_req,
  input wire logic fuse_done,
  output logic lc_secure,
  input wire logic supervisory_flash_prog_req,
  output logic supervisory_flash_prog_grant,
  output logic supervisory_flash_prog_refused
);

  //////////////////////////////////////////////////////////////////////////////
  // Boot hand-off
  boot_state_t boot_state, next_boot_state;
  logic next_debug_port_enable;
  logic [ENTRY_W-1:0] next_boot_entry;

  always_comb begin
    next_boot_state = boot_state;
    next_debug_port_enable = debug_port_enable;
    next_boot_entry = boot_entry;
    unique case (boot_state)
      BOOT_ROM_CHECK: begin
        if (supervisory_flash_check_done) begin
          next_boot_state = supervisory_flash_check_ok ? BOOT_DEBUG_CFG : BOOT_IDLE;
        end
      end
      BOOT_DEBUG_CFG: begin
        next_debug_port_enable = (protection_state != PROT_SECURE) && (protection_state != PROT_DEAD);
        next_boot_state = BOOT_APP_CHECK;
      end
      BOOT_APP_CHECK: begin
        if (app_check_done) begin
          if (app_check_ok) begin
            next_boot_entry = app_entry_addr;
            next_boot_state = BOOT_APP_RUN;
          end else begin
            next_boot_state = BOOT_IDLE;
          end
        end
      end
      BOOT_APP_RUN: next_boot_state = BOOT_APP_RUN;
      BOOT_IDLE: next_boot_state = BOOT_IDLE; // Only reset leaves the idle loop
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      boot_state <= BOOT_ROM_CHECK;
      debug_port_enable <= 1'b0;
      boot_entry <= ENTRY_RST;
    end else begin
      boot_state <= next_boot_state;
      debug_port_enable <= next_debug_port_enable;
      boot_entry <= next_boot_entry;
    end
  end

  assign supervisory_flash_check_req = (boot_state == BOOT_ROM_CHECK);
  assign app_check_req = (boot_state == BOOT_APP_CHECK);
  assign app_running = (boot_state == BOOT_APP_RUN);
  assign boot_idle = (boot_state == BOOT_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration bits; writes before the application runs are dropped
  logic next_bank_mode, next_map_select;

  always_comb begin
    next_bank_mode = bank_mode;
    next_map_select = map_select;
    if (ctl_write && app_running) begin
      next_bank_mode = ctl_bank_mode_in;
      next_map_select = ctl_map_in;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bank_mode <= BANK_MODE_RST;
      map_select <= MAP_RST;
    end else begin
      bank_mode <= next_bank_mode;
      map_select <= next_map_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fetch mapping and read-while-write; uses registered bits only, so a write
  // reaches accesses taken from the next edge on
  logic fetch_half, prog_half, bank_conflict;
  logic next_fetch_valid;
  logic [ADDR_W-1:0] next_fetch_phys_addr;

  always_comb begin
    fetch_half = phys_half(map_select, fetch_addr[BANK_BIT]);
    prog_half = phys_half(map_select, prog_addr[BANK_BIT]);
    // Single bank has no isolation, so any programming stalls fetch
    bank_conflict = prog_active && ((bank_mode == BANK_MODE_SINGLE) || (fetch_half == prog_half));
    fetch_ready = !bank_conflict;
    next_fetch_valid = fetch_req && fetch_ready;
    next_fetch_phys_addr = fetch_phys_addr;
    if (next_fetch_valid) begin
      next_fetch_phys_addr = {fetch_half, fetch_addr[BANK_BIT-1:0]};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fetch_valid <= 1'b0;
      fetch_phys_addr <= PHYS_ADDR_RST;
    end else begin
      fetch_valid <= next_fetch_valid;
      fetch_phys_addr <= next_fetch_phys_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lifecycle transition and supervisory row lock
  life_state_t life_state, next_life_state;
  logic next_supervisory_flash_prog_refused;

  always_comb begin
    next_life_state = life_state;
    unique case (life_state)
      LC_OPEN: if (lc_secure_req) next_life_state = LC_HASH;
      LC_HASH: if (hash_done) next_life_state = LC_FUSE;
      LC_FUSE: if (fuse_done) next_life_state = LC_SECURE;
      LC_SECURE: next_life_state = LC_SECURE;
    endcase
    // Rows also held during the transition so the hash stays valid
    next_supervisory_flash_prog_refused = supervisory_flash_prog_req && (life_state != LC_OPEN);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      life_state <= LC_OPEN;
      supervisory_flash_prog_refused <= 1'b0;
    end else begin
      life_state <= next_life_state;
      supervisory_flash_prog_refused <= next_supervisory_flash_prog_refused;
    end
  end

  assign hash_req = (life_state == LC_HASH);
  assign fuse_req = (life_state == LC_FUSE);
  assign lc_secure = (life_state == LC_SECURE);
  assign supervisory_flash_prog_grant = supervisory_flash_prog_req && (life_state == LC_OPEN);

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_reset_single;
    @(posedge mclk) $rose(resetn) |-> (bank_mode == BANK_MODE_RST) && (map_select == MAP_RST);
  endproperty
  a_reset_single: assert property (p_reset_single) else $error("config not clear after reset");

  property p_boot_keeps;
    @(posedge mclk) disable iff (!resetn) !app_running |=> $stable(bank_mode) && $stable(map_select);
  endproperty
  a_boot_keeps: assert property (p_boot_keeps) else $error("config changed before application");

  property p_write_takes;
    @(posedge mclk) disable iff (!resetn)
      ctl_write && app_running |=> (bank_mode == $past(ctl_bank_mode_in)) && (map_select == $past(ctl_map_in));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("config write lost");

  property p_map_addr;
    @(posedge mclk) disable iff (!resetn)
      fetch_req && fetch_ready |=> fetch_valid && (fetch_phys_addr[BANK_BIT] == ($past(fetch_addr[BANK_BIT]) ^ $past(map_select)));
  endproperty
  a_map_addr: assert property (p_map_addr) else $error("wrong physical half");

  property p_rww;
    @(posedge mclk) disable iff (!resetn)
      prog_active && bank_mode && (fetch_addr[BANK_BIT] != prog_addr[BANK_BIT]) |-> fetch_ready;
  endproperty
  a_rww: assert property (p_rww) else $error("fetch stalled on other bank");

  property p_single_stall;
    @(posedge mclk) disable iff (!resetn) prog_active && !bank_mode |-> !fetch_ready;
  endproperty
  a_single_stall: assert property (p_single_stall) else $error("fetch during single bank program");

  property p_handoff;
    @(posedge mclk) disable iff (!resetn)
      supervisory_flash_check_req && supervisory_flash_check_done && supervisory_flash_check_ok |=> !supervisory_flash_check_req ##1 app_check_req;
  endproperty
  a_handoff: assert property (p_handoff) else $error("no hand-off to flash boot");

  property p_app_jump;
    @(posedge mclk) disable iff (!resetn)
      app_check_req && app_check_done && app_check_ok |=> app_running && (boot_entry == $past(app_entry_addr));
  endproperty
  a_app_jump: assert property (p_app_jump) else $error("no jump to valid application");

  property p_idle_stays;
    @(posedge mclk) disable iff (!resetn) boot_idle |=> boot_idle && !app_running;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("left idle loop without reset");

  property p_lock;
    @(posedge mclk) disable iff (!resetn) lc_secure |-> !supervisory_flash_prog_grant;
  endproperty
  a_lock: assert property (p_lock) else $error("row programmed after secure");

  property p_refuse;
    @(posedge mclk) disable iff (!resetn) supervisory_flash_prog_req && lc_secure |=> supervisory_flash_prog_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal not flagged");

  property p_fuse_after_hash;
    @(posedge mclk) disable iff (!resetn) hash_req && hash_done |=> fuse_req;
  endproperty
  a_fuse_after_hash: assert property (p_fuse_after_hash) else $error("fuse step skipped");

  c_app_run: cover property (@(posedge mclk) disable iff (!resetn) $rose(app_running));
  c_idle: cover property (@(posedge mclk) disable iff (!resetn) $rose(boot_idle));
  c_rww: cover property (@(posedge mclk) disable iff (!resetn) prog_active && fetch_req && fetch_ready);
  c_secure: cover property (@(posedge mclk) disable iff (!resetn) $rose(lc_secure));

endmodule : flash_bank_remap_control

`default_nettype wire

/* sim/tb_flash_bank_remap_control.sv */
// Purpose: Self-checking bench for the bank mode, remap, boot hand-off and lifecycle lock.
// Assumes: Inputs change 2 ns after the rising edge; check agents answer at once.
// Notes: Random fetch and programming addresses come from a fixed seed.
`timescale 1ns/1ps
`default_nettype none

module tb_flash_bank_remap_control;
  import flash_bank_remap_pkg::*;

  // Marker words the update manager keeps per mapping
  localparam logic [31:0] MARKER_MAP_A = 32'hAAAA_AAAA;
  localparam logic [31:0] MARKER_MAP_B = 32'hFFFF_FFFF;

  logic mclk, resetn, ctl_write, ctl_bank_mode_in, ctl_map_in, bank_mode, map_select;
  logic supervisory_flash_check_req, supervisory_flash_check_done, supervisory_flash_check_ok, debug_port_enable;
  logic app_check_req, app_check_done, app_check_ok, app_running, boot_idle;
  logic [1:0] protection_state;
  logic [ENTRY_W-1:0] app_entry_addr, boot_entry;
  logic fetch_req, fetch_ready, fetch_valid, prog_active;
  logic [ADDR_W-1:0] fetch_addr, fetch_phys_addr, prog_addr;
  logic lc_secure_req, hash_req, hash_done, fuse_req, fuse_done, lc_secure;
  logic supervisory_flash_prog_req, supervisory_flash_prog_grant, supervisory_flash_prog_refused;
  int err_count = 0;
  int n_tests = 0;
  logic exp_rdy;
  logic [31:0] rnd;
  logic [31:0] marker;

  flash_bank_remap_control i_dut (
    .mclk(mclk),
    .resetn(resetn),
    .ctl_write(ctl_write),
    .ctl_bank_mode_in(ctl_bank_mode_in),
    .ctl_map_in(ctl_map_in),
    .bank_mode(bank_mode),
    .map_select(map_select),
    .supervisory_flash_check_req(supervisory_flash_check_req),
    .supervisory_flash_check_done(supervisory_flash_check_done),
    .supervisory_flash_check_ok(supervisory_flash_check_ok),
    .protection_state(protection_state),
    .debug_port_enable(debug_port_enable),
    .app_check_req(app_check_req),
    .app_check_done(app_check_done),
    .app_check_ok(app_check_ok),
    .app_entry_addr(app_entry_addr),
    .boot_entry(boot_entry),
    .app_running(app_running),
    .boot_idle(boot_idle),
    .fetch_req(fetch_req),
    .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid),
    .fetch_phys_addr(fetch_phys_addr),
    .prog_active(prog_active),
    .prog_addr(prog_addr),
    .lc_secure_req(lc_secure_req),
    .hash_req(hash_req),
    .hash_done(hash_done),
    .fuse_req(fuse_req),
    .fuse_done(fuse_done),
    .lc_secure(lc_secure),
    .supervisory_flash_prog_req(supervisory_flash_prog_req),
    .supervisory_flash_prog_grant(supervisory_flash_prog_grant),
    .supervisory_flash_prog_refused(supervisory_flash_prog_refused)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Conflict only when programming shares the physical half, or in single bank
  function automatic logic ready_of(input logic bm, input logic mp, input logic pa,
                                    input logic [ADDR_W-1:0] fa, input logic [ADDR_W-1:0] pr);
    ready_of = !(pa && (!bm || ((fa[BANK_BIT] ^ mp) == (pr[BANK_BIT] ^ mp))));
  endfunction : ready_of

  task automatic do_reset;
    resetn = 1'b0;
    #1;
    chk(bank_mode, 1'h0);
    chk(map_select, 1'h0);
    chk(debug_port_enable, 1'h0);
    cyc(16);
    resetn = 1'b1;
    chk(supervisory_flash_check_req, 1'h1);
  endtask : do_reset

  // Writes stand for SRAM-resident code, never flash-fetched code
  task automatic wr(input logic bm, input logic mp);
    ctl_bank_mode_in = bm;
    ctl_map_in = mp;
    ctl_write = 1'b1;
    cyc(1);
    ctl_write = 1'b0;
  endtask : wr

  task automatic boot(input logic [1:0] prot, input logic s_ok, input logic a_ok);
    logic [31:0] addr;
    addr = $urandom;
    protection_state = prot;
    app_entry_addr = addr;
    supervisory_flash_check_ok = s_ok;
    supervisory_flash_check_done = 1'b1;
    cyc(1);
    supervisory_flash_check_done = 1'b0;
    if (!s_ok) begin
      chk(boot_idle, 1'h1);
    end else begin
      cyc(1);
      chk(app_check_req, 1'h1);
      chk(debug_port_enable, prot < 2'h2);
      app_check_ok = a_ok;
      app_check_done = 1'b1;
      cyc(1);
      app_check_done = 1'b0;
      chk(app_running, a_ok);
      chk(boot_idle, !a_ok);
      if (a_ok) chk(boot_entry, addr);
    end
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {ctl_write, ctl_bank_mode_in, ctl_map_in, supervisory_flash_check_done, supervisory_flash_check_ok} = 5'h00;
    {app_check_done, app_check_ok, fetch_req, prog_active, lc_secure_req} = 5'h00;
    {hash_done, fuse_done, supervisory_flash_prog_req} = 3'h0;
    protection_state = 2'h0;
    app_entry_addr = 32'h0000_0000;
    fetch_addr = 23'h00_0000;
    prog_addr = 23'h00_0000;
    rnd = 32'h0000_0000;
    marker = MARKER_MAP_A;
    void'($urandom(22));
    do_reset();
    wr(1'b1, 1'b1);
    chk({bank_mode, map_select}, 2'h0);
    boot(PROT_NORMAL, 1'b1, 1'b1);
    // Request held up across the loop, so it is never lowered and raised at once
    fetch_req = 1'b1;
    for (int i = 0; i < 44; i++) begin
      if (i % 4 == 0) wr(i[2], i[3]);
      if (i % 4 == 0) chk({bank_mode, map_select}, {i[2], i[3]});
      rnd = $urandom;
      prog_addr = {rnd[BANK_BIT] & !i[3], rnd[BANK_BIT-1:0]};
      fetch_addr = 23'($urandom);
      prog_active = 1'($urandom);
      #1;
      exp_rdy = ready_of(i[2], i[3], prog_active, fetch_addr, prog_addr);
      chk(fetch_ready, exp_rdy);
      cyc(1);
      chk(fetch_valid, exp_rdy);
      if (exp_rdy) chk(fetch_phys_addr, {fetch_addr[BANK_BIT] ^ i[3], fetch_addr[BANK_BIT-1:0]});
    end
    fetch_req = 1'b0;
    prog_active = 1'b0;
    // Last update finished under mapping B
    marker = MARKER_MAP_B;
    supervisory_flash_prog_req = 1'b1;
    lc_secure_req = 1'b1;
    #1;
    chk(supervisory_flash_prog_grant, 1'h1);
    cyc(1);
    lc_secure_req = 1'b0;
    chk({hash_req, supervisory_flash_prog_grant}, 2'h2);
    hash_done = 1'b1;
    cyc(1);
    hash_done = 1'b0;
    chk(fuse_req, 1'h1);
    fuse_done = 1'b1;
    cyc(1);
    fuse_done = 1'b0;
    chk({lc_secure, supervisory_flash_prog_refused}, 2'h3);
    // Request kept one more cycle so the lock is seen in the secure stage
    cyc(1);
    chk({lc_secure, supervisory_flash_prog_refused, supervisory_flash_prog_grant}, 3'h6);
    supervisory_flash_prog_req = 1'b0;
    do_reset();
    boot(PROT_DEAD, 1'b1, 1'b0);
    wr(1'b1, 1'b1);
    chk({bank_mode, map_select}, 2'h0);
    do_reset();
    boot(PROT_SECURE, 1'b0, 1'b1);
    // Every protection state through a good boot; mapping restored from the marker
    for (int p = 0; p < 4; p++) begin
      do_reset();
      boot(2'(p), 1'b1, 1'b1);
      wr(1'b0, marker == MARKER_MAP_B);
      chk({bank_mode, map_select}, {1'b0, marker == MARKER_MAP_B});
    end
    end_of_test();
  end

  // About 200 cycles expected; 2000 means a hang
  initial begin
    #(2000 * 20);
    err_count++;
    end_of_test();
  end

endmodule : tb_flash_bank_remap_control

`default_nettype wire
